// ---- design/io_space_device.sv ----
// I/O space decoder and register bank facing the processor core.
//
// Notes on behaviour
// [RL1] Load and store reach every I/O location.
// [RL2] Set and clear one bit, low range.
// [RL3] Test one bit, report skip.
// [RL4] In and out use I/O addresses 0x00-0x3F.
// [RL5] Data-space address is I/O address plus 0x20.
// [RL6] Writing one clears a status flag.
// [RL7] Bit operations touch only the chosen bit.
// [RL8] Bit operations refused above I/O 0x1F.
// [RL9] Three general purpose storage registers.
// [RL10] Address-high bits 7:1 read zero.
// [RL11] Address-high bit 0 only on largest variant.
// [RL12] Address undefined until software loads it.
// [RL13] Software writes zero to reserved bits.
// [RL14] Software never writes reserved addresses.
module io_space_device
  import io_space_pkg::*;
#(
  parameter int EE_ADDR_BITS = 9
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  io_bus_if.dev           bus,
  input  wire logic [7:0] flag_events,
  output logic      [7:0] status_flags,
  output logic      [7:0] gpr0,
  output logic      [7:0] gpr1,
  output logic      [7:0] gpr2,
  output logic      [8:0] eeprom_address
);

  function automatic logic is_write(input op_e o);
    return (o == OP_STORE) || (o == OP_OUT) ||
           (o == OP_SET_BIT) || (o == OP_CLR_BIT);
  endfunction

  function automatic logic is_bit_op(input op_e o);
    return (o == OP_SET_BIT) || (o == OP_CLR_BIT) ||
           (o == OP_SKIP_SET) || (o == OP_SKIP_CLR);
  endfunction

  logic [7:0] eeprom_addr_low;
  logic       eeprom_addr_msb;

  // Address normalisation: every operation lands on a 6-bit I/O address.
  wire        is_data_op = (bus.op == OP_LOAD) || (bus.op == OP_STORE);
  wire        data_ok    = (bus.addr >= DATA_OFFSET) &&
                           (bus.addr <= DATA_LAST);          // RL1
  wire [7:0]  data_io    = bus.addr - DATA_OFFSET;           // RL5
  wire        io_ok      = (bus.addr <= IO_LAST);            // RL4
  wire        bit_ok     = (bus.addr <= BIT_IO_LAST);        // RL8
  wire [5:0]  io_addr    = is_data_op ? data_io[5:0] : bus.addr[5:0];
  wire        range_ok   = is_data_op ? data_ok :
                           is_bit_op(bus.op) ? bit_ok : io_ok;

  wire sel_flag = (io_addr == FLAG_IO);
  wire sel_g0   = (io_addr == GPR0_IO);
  wire sel_g1   = (io_addr == GPR1_IO);
  wire sel_g2   = (io_addr == GPR2_IO);
  wire sel_eel  = (io_addr == EE_LOW_IO);
  wire sel_eeh  = (io_addr == EE_HIGH_IO);
  wire mapped   = sel_flag | sel_g0 | sel_g1 | sel_g2 | sel_eel | sel_eeh;

  // Reserved bits read as zero; bit 0 exists only with the deep array.
  wire        has_msb   = (EE_ADDR_BITS >= EE_BITS_MAX);
  wire [7:0]  ee_high_rd = has_msb ? {7'h00, eeprom_addr_msb} : 8'h00; // RL10

  wire [7:0] read_val = sel_flag ? status_flags :
                        sel_g0   ? gpr0 :
                        sel_g1   ? gpr1 :
                        sel_g2   ? gpr2 :
                        sel_eel  ? eeprom_addr_low :
                        sel_eeh  ? ee_high_rd : 8'h00;

  wire [7:0] wr_val;
  wire       skip_now;

  io_bit_alu u_alu (
    .op      (bus.op),
    .bit_sel (bus.bit_sel),
    .old_val (read_val),
    .wdata   (bus.wdata),
    .is_w1c  (sel_flag),
    .wr_val  (wr_val),
    .skip    (skip_now)
  );

  // A request is taken only while ack is low, so a request that is still
  // up in the cycle of its own ack is never taken a second time.
  wire take   = bus.req && !bus.ack;
  wire good   = take && range_ok && mapped;
  wire do_wr  = good && is_write(bus.op);
  // Refused operations write nothing and answer with the error set.
  wire refuse = take && !(range_ok && mapped);

  // Write strobes, one per register, keep each flop block down to a
  // single choice and put the whole write decode in one place.
  wire wr_flag = do_wr && sel_flag;
  wire wr_g0   = do_wr && sel_g0;
  wire wr_g1   = do_wr && sel_g1;
  wire wr_g2   = do_wr && sel_g2;
  wire wr_eel  = do_wr && sel_eel;
  // Without the deep array the top address bit has no storage at all.
  wire wr_eeh  = do_wr && sel_eeh && has_msb;

  wire [7:0] flag_clr    = wr_flag ? wr_val : 8'h00; // RL6
  // A flag raised in the same cycle as its clear survives, so an event
  // that lands while software acknowledges an older one is never lost.
  wire [7:0] next_flags  = (status_flags & ~flag_clr) | flag_events;

  // Storage registers take the write value, already merged per bit for
  // the set and clear operations.
  wire [7:0] next_g0     = wr_g0 ? wr_val : gpr0; // RL9
  wire [7:0] next_g1     = wr_g1 ? wr_val : gpr1; // RL9
  wire [7:0] next_g2     = wr_g2 ? wr_val : gpr2; // RL9

  // The low address byte is plain storage; the top bit is masked.
  wire [7:0] ee_msb_wr   = wr_val & EE_HIGH_MASK;                   // RL11
  wire [7:0] next_ee_low = wr_eel ? wr_val : eeprom_addr_low;
  wire       next_ee_msb = wr_eeh ? ee_msb_wr[0] : eeprom_addr_msb; // RL11

  // Answer fields are loaded only when a request is taken, so the core
  // may read them at leisure until its next request.
  wire [7:0] next_rdata  = good ? read_val : REG_RESET; // RL1
  wire       next_skip   = good && skip_now;            // RL3
  wire       next_err    = refuse;                      // RL8

  // Status flags load every cycle because events may arrive at any time.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_flags <= REG_RESET;
    end else begin
      status_flags <= next_flags; // RL6
    end
  end

  // The three storage registers keep whatever was written last.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gpr0 <= REG_RESET;
    end else begin
      gpr0 <= next_g0; // RL9
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gpr1 <= REG_RESET;
    end else begin
      gpr1 <= next_g1; // RL9
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gpr2 <= REG_RESET;
    end else begin
      gpr2 <= next_g2; // RL9
    end
  end

  // Software is expected to load the address before use; the cleared
  // value after reset is just one legal reading of an undefined value.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eeprom_addr_low <= REG_RESET; // RL12
    end else begin
      eeprom_addr_low <= next_ee_low;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eeprom_addr_msb <= 1'b0; // RL12
    end else begin
      eeprom_addr_msb <= next_ee_msb; // RL11
    end
  end

  // The outward view repeats the mask so a shallow build never shows a
  // one in the top bit.
  assign eeprom_address = {eeprom_addr_msb & has_msb, eeprom_addr_low};

  // Answers are registered: the core sees ack one edge after its request,
  // and ack drops at the next edge because a take needs ack low.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus.ack <= 1'b0;
    end else begin
      bus.ack <= take;
    end
  end

  // Skip is only ever raised for the two bit test operations.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus.rdata <= REG_RESET;
      bus.skip  <= 1'b0;
      bus.err   <= 1'b0;
    end else if (take) begin
      bus.rdata <= next_rdata; // RL1
      bus.skip  <= next_skip;  // RL3
      bus.err   <= next_err;   // RL8
    end
  end

endmodule // io_space_device

// ---- inc/io_space_pkg.sv ----
// Shared constants and types for the I/O space access block.
package io_space_pkg;

  localparam int DATA_W = 8;

  typedef enum logic [2:0] {
    OP_LOAD     = 3'b000,
    OP_STORE    = 3'b001,
    OP_IN       = 3'b010,
    OP_OUT      = 3'b011,
    OP_SET_BIT  = 3'b100,
    OP_CLR_BIT  = 3'b101,
    OP_SKIP_SET = 3'b110,
    OP_SKIP_CLR = 3'b111
  } op_e;

  // I/O address space limits and data-space offset.
  localparam logic [7:0] IO_LAST      = 8'h3F;
  localparam logic [7:0] BIT_IO_LAST  = 8'h1F;
  localparam logic [7:0] DATA_OFFSET  = 8'h20;
  localparam logic [7:0] DATA_LAST    = 8'h5F;

  // I/O addresses of the implemented registers.
  localparam logic [5:0] FLAG_IO      = 6'h08;
  localparam logic [5:0] GPR0_IO      = 6'h0A;
  localparam logic [5:0] GPR1_IO      = 6'h0B;
  localparam logic [5:0] GPR2_IO      = 6'h2A;
  localparam logic [5:0] EE_LOW_IO    = 6'h1E;
  localparam logic [5:0] EE_HIGH_IO   = 6'h1F;

  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] EE_HIGH_MASK = 8'h01;
  localparam int         EE_BITS_MAX  = 9;

  // Controller register byte offsets on the software bus.
  localparam logic [3:0] CMD_OFS      = 4'h0;
  localparam logic [3:0] WDATA_OFS    = 4'h4;
  localparam logic [3:0] STATUS_OFS   = 4'h8;

  // Field positions in the command and status words.
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BIT_LSB  = 8;
  localparam int CMD_ADDR_LSB = 16;
  localparam int STAT_SKIP_BIT = 8;
  localparam int STAT_ERR_BIT  = 9;
  localparam int STAT_BUSY_BIT = 10;
  localparam int STAT_DONE_BIT = 11;

endpackage

// ---- inc/io_bus_if.sv ----
// Request and answer channel between the processor core and the I/O space.
interface io_bus_if;
  import io_space_pkg::*;

  logic       req;
  op_e        op;
  logic [7:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       skip;
  logic       err;

  modport core (output req, op, addr, bit_sel, wdata,
                input  ack, rdata, skip, err);
  modport dev  (input  req, op, addr, bit_sel, wdata,
                output ack, rdata, skip, err);
endinterface

// ---- design/io_bit_alu.sv ----
// Bit set, clear and test operand builder for the low I/O range.
module io_bit_alu
  import io_space_pkg::*;
(
  input  wire op_e        op,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] old_val,
  input  wire logic [7:0] wdata,
  input  wire logic       is_w1c,
  output logic      [7:0] wr_val,
  output logic            skip
);

  wire [7:0] one_hot  = 8'h01 << bit_sel;
  wire       bit_now  = old_val[bit_sel];
  // Status flags see a lone one at the chosen bit, so a set clears only
  // that flag and a clear writes nothing at all.
  wire [7:0] set_val  = is_w1c ? one_hot : (old_val | one_hot); // RL7
  wire [7:0] clr_val  = is_w1c ? 8'h00 : (old_val & ~one_hot);  // RL7

  assign wr_val = (op == OP_SET_BIT) ? set_val :               // RL2
                  (op == OP_CLR_BIT) ? clr_val : wdata;        // RL2
  assign skip   = ((op == OP_SKIP_SET) &&  bit_now) ||         // RL3
                  ((op == OP_SKIP_CLR) && !bit_now);           // RL3

endmodule // io_bit_alu

// ---- design/io_core_master.sv ----
// Processor-core end: software orders I/O operations over Avalon-MM.
module io_core_master
  import io_space_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  io_bus_if.core           bus,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_WAIT = 1'b1
  } state_e;

  state_e     state;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic       skip_reg;
  logic       err_reg;
  logic       done;
  logic       rd_ready;

  wire sel_cmd    = (avs_address == CMD_OFS);
  wire sel_wdata  = (avs_address == WDATA_OFS);
  wire sel_status = (avs_address == STATUS_OFS);
  wire busy       = (state == S_WAIT);

  // A command write stalls while one is in flight; reads take one wait.
  assign avs_waitrequest = (avs_write && sel_cmd && busy) ||
                           (avs_read && !rd_ready);

  wire wr_take = avs_write && !avs_waitrequest;
  wire launch  = wr_take && sel_cmd && avs_byteenable[0];
  wire [2:0] cmd_op = avs_writedata[CMD_OP_LSB +: 3];
  wire [7:0] cmd_ad = avs_writedata[CMD_ADDR_LSB +: 8];
  // Short-form in and out carry only a 6-bit I/O address.
  wire       short_io = (op_e'(cmd_op) == OP_IN) || (op_e'(cmd_op) == OP_OUT);
  wire [7:0] cmd_addr = short_io ? (cmd_ad & IO_LAST) : cmd_ad; // RL4

  wire [31:0] status_word = {20'h00000, done, busy, err_reg, skip_reg,
                             rdata_reg};
  wire [31:0] rd_mux = sel_cmd    ? {8'h00, bus.addr, 5'h00, bus.bit_sel,
                                     5'h00, bus.op} :
                       sel_wdata  ? {24'h000000, wdata_reg} :
                       sel_status ? status_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_ready     <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_ready <= avs_read && !rd_ready;
      if (avs_read && !rd_ready) avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wdata_reg <= 8'h00;
    end else if (wr_take && sel_wdata && avs_byteenable[0]) begin
      wdata_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state       <= S_IDLE;
      bus.req     <= 1'b0;
      bus.op      <= OP_LOAD;
      bus.addr    <= 8'h00;
      bus.bit_sel <= 3'h0;
      bus.wdata   <= 8'h00;
      rdata_reg   <= 8'h00;
      skip_reg    <= 1'b0;
      err_reg     <= 1'b0;
      done        <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (launch) begin
            bus.req     <= 1'b1;
            bus.op      <= op_e'(cmd_op);
            bus.addr    <= cmd_addr;
            bus.bit_sel <= avs_writedata[CMD_BIT_LSB +: 3];
            bus.wdata   <= wdata_reg;
            done        <= 1'b0;
            state       <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (bus.ack) begin
            bus.req   <= 1'b0;
            rdata_reg <= bus.rdata;
            skip_reg  <= bus.skip;
            err_reg   <= bus.err;
            done      <= 1'b1;
            state     <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // io_core_master

// ---- verification/io_space_monitor.sv ----
// Concurrent checks on the channel between the core and the I/O space.
module io_space_monitor
  import io_space_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       req,
  input wire op_e        op,
  input wire logic [7:0] addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       skip,
  input wire logic       err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ack_in_time_a: assert property (req && !ack |=> ack)
    else $error("ack late after request");
  ack_pulse_a: assert property (ack |=> !ack && !req)
    else $error("ack or request held too long");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  req_steady_a: assert property (req && !ack |=>
    $stable(op) && $stable(addr) && $stable(bit_sel) && $stable(wdata))
    else $error("request changed before ack");
  bit_range_a: assert property (
    ack && op[2] && addr > BIT_IO_LAST |-> err)
    else $error("bit operation above low range accepted");
  data_range_a: assert property (
    ack && (op == OP_LOAD || op == OP_STORE) &&
    (addr < DATA_OFFSET || addr > DATA_LAST) |-> err)
    else $error("data address outside window accepted");
  io_range_a: assert property (
    ack && (op == OP_IN || op == OP_OUT) |-> addr <= IO_LAST)
    else $error("short form address out of range");
  refused_zero_a: assert property (ack && err |-> rdata == 8'h00)
    else $error("refused access returned data");
  skip_only_a: assert property (
    ack && op != OP_SKIP_SET && op != OP_SKIP_CLR |-> !skip)
    else $error("skip without bit test");
  answer_hold_a: assert property (
    !ack |-> $stable(rdata) && $stable(skip) && $stable(err))
    else $error("answer changed between acks");
endmodule // io_space_monitor

// ---- verification/io_space_register_access_tb_top.sv ----
// Bench joining the core master and the I/O space device face to face.
module io_space_register_access_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import io_space_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  flag_events = 8'h00;
  logic [7:0]  status_flags, gpr0, gpr1, gpr2;
  logic [8:0]  eeprom_address;
  logic [31:0] stat_word;
  logic [7:0]  v;
  logic [2:0]  b;
  int          failures = 0;
  int          num_checks = 0;
  int          seed = 70;
  io_bus_if bus ();
  always #25 clk = ~clk;

  io_core_master i_io_core_master (.clk(clk), .reset_n(reset_n), .bus(bus),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  io_space_device #(.EE_ADDR_BITS(9)) i_io_space_device (.clk(clk),
    .reset_n(reset_n), .bus(bus), .flag_events(flag_events),
    .status_flags(status_flags), .gpr0(gpr0), .gpr1(gpr1), .gpr2(gpr2),
    .eeprom_address(eeprom_address));
  io_space_monitor i_io_space_monitor (.clk(clk), .reset_n(reset_n),
    .req(bus.req), .op(bus.op), .addr(bus.addr), .bit_sel(bus.bit_sel),
    .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata), .skip(bus.skip),
    .err(bus.err));

  function automatic logic [7:0] with_bit(logic [7:0] x, logic [2:0] i,
                                          logic s);
    with_bit = x;
    with_bit[i] = s;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Waitrequest and read data are read as the rising edge arrives, before
  // that edge's own updates land, so both are the values it samples.
  task automatic avs(input logic rd, input logic [3:0] a,
                     input logic [31:0] d);
    int   n;
    logic w;
    n = 0;
    w = 1'b1;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    while (w !== 1'b0 && n < 50) begin
      @(posedge clk);
      w = avs_waitrequest;
      stat_word = avs_readdata;
      n++;
    end
    if (w !== 1'b0) begin
      failures++;
      conclude();
    end else begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic run(input op_e o, input logic [7:0] a, input logic [2:0] bs,
                     input logic [7:0] d);
    int n;
    n = 0;
    avs(1'b0, WDATA_OFS, {24'h0, d});
    avs(1'b0, CMD_OFS, {8'h0, a, 5'h0, bs, 5'h0, o});
    do begin
      avs(1'b1, STATUS_OFS, 32'h0);
      n++;
    end while (stat_word[STAT_BUSY_BIT] !== 1'b0 && n < 20);
    if (stat_word[STAT_BUSY_BIT] !== 1'b0) begin
      failures++;
      conclude();
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      b = $random(seed);
      run(OP_STORE, {2'h0, GPR0_IO} + DATA_OFFSET, 3'h0, v);
      check(gpr0, v);
      run(OP_LOAD, {2'h0, GPR0_IO} + DATA_OFFSET, 3'h0, 8'h00);
      check(stat_word[7:0], v);
      run(OP_OUT, {2'h0, GPR2_IO}, 3'h0, ~v);
      check(gpr2, 8'(~v));
      run(OP_IN, {2'h0, GPR2_IO}, 3'h0, 8'h00);
      check(stat_word[7:0], 8'(~v));
      run(OP_OUT, {2'h0, GPR1_IO}, 3'h0, v);
      run(OP_SET_BIT, {2'h0, GPR1_IO}, b, 8'h00);
      check(gpr1, with_bit(v, b, 1'b1));
      run(OP_SKIP_SET, {2'h0, GPR1_IO}, b, 8'h00);
      check(stat_word[STAT_SKIP_BIT], 1'b1);
      run(OP_CLR_BIT, {2'h0, GPR1_IO}, b, 8'h00);
      check(gpr1, with_bit(v, b, 1'b0));
      run(OP_SKIP_CLR, {2'h0, GPR1_IO}, b, 8'h00);
      check(stat_word[STAT_SKIP_BIT], 1'b1);
      run(OP_SKIP_SET, {2'h0, GPR1_IO}, b, 8'h00);
      check(stat_word[STAT_SKIP_BIT], 1'b0);
      run(OP_SET_BIT, {2'h0, GPR2_IO}, b, 8'h00);
      check(stat_word[STAT_ERR_BIT], 1'b1);
      check(gpr2, 8'(~v));
    end
    // A short-form address above the I/O range loses its top two bits.
    run(OP_IN, {2'h3, GPR2_IO}, 3'h0, 8'h00);
    check(stat_word[7:0], 8'(~v));
    avs(1'b1, CMD_OFS, 32'h0);
    check(stat_word, {8'h00, 2'h0, GPR2_IO, 5'h00, 3'h0, 5'h00,
                      OP_IN});
    flag_events <= 8'hFF;
    @(posedge clk);
    flag_events <= 8'h00;
    @(posedge clk);
    run(OP_SET_BIT, {2'h0, FLAG_IO}, 3'h3, 8'h00);
    check(status_flags, 8'hF7);
    run(OP_STORE, {2'h0, FLAG_IO} + DATA_OFFSET, 3'h0, 8'h0F);
    check(status_flags, 8'hF0);
    run(OP_OUT, {2'h0, FLAG_IO}, 3'h0, 8'h00);
    run(OP_CLR_BIT, {2'h0, FLAG_IO}, 3'h5, 8'h00);
    check(status_flags, 8'hF0);
    run(OP_OUT, {2'h0, EE_HIGH_IO}, 3'h0, 8'h01);
    run(OP_IN, {2'h0, EE_HIGH_IO}, 3'h0, 8'h00);
    check(stat_word[7:0], 8'h01);
    check(eeprom_address[8], 1'b1);
    run(OP_LOAD, 8'h60, 3'h0, 8'h00);
    check(stat_word[STAT_ERR_BIT], 1'b1);
    check(stat_word[7:0], 8'h00);
    conclude();
  end
endmodule // io_space_register_access_tb_top
